/* src/ats_mode_pkg.sv */
// constants, types and enumerations shared by the mode and key logic
// Overview of operation
// - auto key in auto mode returns to manual
// - key I closes lower switch, upper off
// - key I with lower on does nothing
// - key O opens lower, upper stays off
// - key II closes upper, lower held off
// - key I with upper on: open first
// - auto entry refused in test or setup
// - auto key in manual enters auto mode
// - delay elapses before switching or return
// - side one: delay 0/5/10/30, return equal
// - side two: same delay, return 300 s
// - basic variant thresholds 5 to 20 percent
// - extended variants add 25 and 30 percent
// - unbalance limit equals voltage threshold
// - setup only from manual at setup position
// - setup offers three operating modes
// - setup offers three switch types
// - auto key in setup steps combination, LEDs
// - test position: auto key steps sequence
// - handle attached forces manual, alarm on
// - handle removed: stay manual, alarm off
// - display variant takes config from display
package ats_mode_pkg;
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned DEBOUNCE_MS   = 20;
   localparam int unsigned DEBOUNCE_CYC  = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int unsigned SEC_CYC       = CLK_HZ;
   localparam int unsigned BACK_FIXED_S  = 300;
   localparam int unsigned DELAY_W       = 9;
   // delay selector codes (2 bits) map to seconds
   localparam logic [8:0] DELAY_S0 = 9'h000;
   localparam logic [8:0] DELAY_S1 = 9'h005;
   localparam logic [8:0] DELAY_S2 = 9'h00A;
   localparam logic [8:0] DELAY_S3 = 9'h01E;
   // threshold selector codes
   localparam logic [2:0] LIM_P5    = 3'h0;
   localparam logic [2:0] LIM_P10   = 3'h1;
   localparam logic [2:0] LIM_P15   = 3'h2;
   localparam logic [2:0] LIM_P20   = 3'h3;
   localparam logic [2:0] LIM_P25   = 3'h4;
   localparam logic [2:0] LIM_P30   = 3'h5;
   localparam logic [2:0] LIM_TEST  = 3'h6;
   localparam logic [2:0] LIM_SETUP = 3'h7;
   localparam logic [4:0] PCT_5  = 5'h05;
   localparam logic [4:0] PCT_10 = 5'h0A;
   localparam logic [4:0] PCT_15 = 5'h0F;
   localparam logic [4:0] PCT_20 = 5'h14;
   localparam logic [4:0] PCT_25 = 5'h19;
   localparam logic [4:0] PCT_30 = 5'h1E;
   // operating modes and switch types
   localparam logic [1:0] OPM_LINE1 = 2'h0;
   localparam logic [1:0] OPM_NOPRI = 2'h1;
   localparam logic [1:0] OPM_MANBK = 2'h2;
   localparam logic [1:0] OPM_LINE2 = 2'h3;
   localparam logic [1:0] SWT_AUTO  = 2'h0;
   localparam logic [1:0] SWT_SMALL = 2'h1;
   localparam logic [1:0] SWT_LARGE = 2'h2;
   localparam logic [2:0] TEST_STEPS = 3'h5;
   typedef enum logic [5:0] {
      ST_MANUAL = 6'h01,
      ST_AUTO   = 6'h02,
      ST_SETUP  = 6'h04,
      ST_TEST   = 6'h08,
      ST_OPEN2  = 6'h10,
      ST_CLOSE1 = 6'h20
   } mode_e;
endpackage

/* src/key_debounce.sv */
// debouncer for one key: two-flop synchroniser, stable filter, press pulse
`timescale 1ns/10ps
module key_debounce #(
   parameter int unsigned STABLE_CYC = ats_mode_pkg::DEBOUNCE_CYC
) (
   // clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rstn,
   // raw key and press pulse
   input  wire logic i_key,
   output logic      o_press
);
   localparam int unsigned CW = $clog2(STABLE_CYC + 1);
   typedef struct packed {
      logic          s1;
      logic          s2;
      logic          stable;
      logic [CW-1:0] cnt;
      logic          press;
   } deb_s;
   deb_s r, nxt;

   // count while the synchronised level differs from the stable one
   always_comb begin
      nxt       = r;
      nxt.s1    = i_key;
      nxt.s2    = r.s1;
      nxt.press = 1'b0;
      if (r.s2 == r.stable) begin
         nxt.cnt = '0;
      end else if (r.cnt == CW'(STABLE_CYC - 1)) begin
         nxt.cnt    = '0;
         nxt.stable = r.s2;
         nxt.press  = r.s2; // one pulse per press
      end else begin
         nxt.cnt = r.cnt + CW'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   assign o_press = r.press;
endmodule

/* src/transfer_switch_mode_control.sv */
// front-panel mode, key and delay logic of the change-over switch control unit
`timescale 1ns/10ps
module transfer_switch_mode_control #(
   parameter int unsigned SEC_CYC     = ats_mode_pkg::SEC_CYC,
   parameter int unsigned DEBOUNCE    = ats_mode_pkg::DEBOUNCE_CYC,
   parameter bit          EXTENDED    = 1'b1,
   parameter bit          DISPLAY_VAR = 1'b0
) (
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rstn,
   // keypad (active high while held)
   input  wire logic       i_key_auto,
   input  wire logic       i_key_one,
   input  wire logic       i_key_off,
   input  wire logic       i_key_two,
   // rotary selectors
   input  wire logic [1:0] i_delay_sel,
   input  wire logic       i_delay_side,
   input  wire logic [2:0] i_lim_sel,
   // switch feedback and handle sense
   input  wire logic       i_sw1_on,
   input  wire logic       i_sw2_on,
   input  wire logic       i_handle,
   // line conditions that trigger a switching or return sequence
   input  wire logic       i_switch_cond,
   input  wire logic       i_back_cond,
   // display configuration
   input  wire logic [1:0] i_disp_opmode,
   input  wire logic [1:0] i_disp_swtype,
   input  wire logic       i_disp_manbk,
   // switch commands
   output logic            o_sw1_close,
   output logic            o_sw1_open,
   output logic            o_sw2_close,
   output logic            o_sw2_open,
   // indicators
   output logic            o_led_power,
   output logic            o_led_auto,
   output logic            o_led_alarm,
   output logic [1:0]      o_led_line,
   // settings and status
   output logic            o_auto_mode,
   output logic            o_setup_mode,
   output logic            o_test_mode,
   output logic [2:0]      o_test_step,
   output logic [1:0]      o_opmode,
   output logic [1:0]      o_swtype,
   output logic [4:0]      o_volt_lim_pct,
   output logic [4:0]      o_unbal_lim_pct,
   output logic            o_switch_go,
   output logic            o_back_go
);
   localparam int unsigned SW = $clog2(SEC_CYC + 1);

   // presses from the four keys
   logic [3:0] key_raw;
   logic [3:0] press;
   assign key_raw = {i_key_two, i_key_off, i_key_one, i_key_auto};

   // one debouncer per key
   for (genvar k = 0; k < 4; k++) begin : g_key
      key_debounce #(.STABLE_CYC(DEBOUNCE)) u_deb (
         .i_ref_clk (i_ref_clk),
         .i_rstn    (i_rstn),
         .i_key     (key_raw[k]),
         .o_press   (press[k])
      );
   end

   typedef struct packed {
      logic [11:0]         s1;
      logic [11:0]         s2;
      ats_mode_pkg::mode_e st;
      logic [1:0]          opm;
      logic [1:0]          swt;
      logic [2:0]          step;
      logic [SW-1:0]       pre;
      logic [8:0]          sw_cnt;
      logic [8:0]          bk_cnt;
      logic                sw1_close;
      logic                sw1_open;
      logic                sw2_close;
      logic                sw2_open;
      logic                led_auto;
      logic                led_alarm;
      logic [1:0]          led_line;
      logic [4:0]          lim_pct;
      logic                sw_go;
      logic                bk_go;
   } ctl_s;
   ctl_s r, nxt;

   // synchronised pin levels: {handle, sw2, sw1, sw_cond, bk_cond, side, delay[1:0], lim[2:0], x}
   logic       handle;
   logic       sw1_on;
   logic       sw2_on;
   logic       sw_cond;
   logic       bk_cond;
   logic       side;
   logic [1:0] dsel;
   logic [2:0] lim;
   assign {handle, sw2_on, sw1_on, sw_cond, bk_cond, side, dsel, lim} = r.s2[11:1];

   // derived settings
   logic       lim_normal;
   logic       lim_ok;
   logic [8:0] sw_delay;
   logic [8:0] bk_delay;
   logic       tick;
   logic [4:0] pct;
   logic [1:0] eff_opm;
   logic [1:0] eff_swt;

   always_comb begin
      unique case (dsel)
         2'h0:    sw_delay = ats_mode_pkg::DELAY_S0;
         2'h1:    sw_delay = ats_mode_pkg::DELAY_S1;
         2'h2:    sw_delay = ats_mode_pkg::DELAY_S2;
         default: sw_delay = ats_mode_pkg::DELAY_S3;
      endcase
      // side two fixes the return delay, side one mirrors the switching delay
      bk_delay = side ? 9'(ats_mode_pkg::BACK_FIXED_S) : sw_delay;
      lim_normal = (lim != ats_mode_pkg::LIM_TEST) && (lim != ats_mode_pkg::LIM_SETUP);
      // basic variant lacks the two widest thresholds
      lim_ok = lim_normal && (EXTENDED || (lim <= ats_mode_pkg::LIM_P20));
      unique case (lim)
         ats_mode_pkg::LIM_P5:  pct = ats_mode_pkg::PCT_5;
         ats_mode_pkg::LIM_P10: pct = ats_mode_pkg::PCT_10;
         ats_mode_pkg::LIM_P15: pct = ats_mode_pkg::PCT_15;
         ats_mode_pkg::LIM_P20: pct = ats_mode_pkg::PCT_20;
         ats_mode_pkg::LIM_P25: pct = EXTENDED ? ats_mode_pkg::PCT_25 : ats_mode_pkg::PCT_20;
         ats_mode_pkg::LIM_P30: pct = EXTENDED ? ats_mode_pkg::PCT_30 : ats_mode_pkg::PCT_20;
         default:               pct = r.lim_pct; // test/setup keep last threshold
      endcase
      // the display variant takes priority, type and return mode from its menu
      eff_opm = DISPLAY_VAR ? (i_disp_manbk ? ats_mode_pkg::OPM_MANBK : i_disp_opmode)
                            : r.opm;
      eff_swt = DISPLAY_VAR ? i_disp_swtype : r.swt;
      tick = (r.pre == SW'(SEC_CYC - 1));
   end

   // next-state logic for mode, key commands and delay timers
   always_comb begin
      nxt           = r;
      nxt.s1        = {i_handle, i_sw2_on, i_sw1_on, i_switch_cond, i_back_cond,
                       i_delay_side, i_delay_sel, i_lim_sel, 1'b0};
      nxt.s2        = r.s1;
      nxt.sw1_close = 1'b0;
      nxt.sw1_open  = 1'b0;
      nxt.sw2_close = 1'b0;
      nxt.sw2_open  = 1'b0;
      nxt.sw_go     = 1'b0;
      nxt.bk_go     = 1'b0;
      nxt.pre       = tick ? '0 : r.pre + SW'(1);
      nxt.lim_pct   = pct;
      nxt.led_line  = {sw2_on, sw1_on};

      unique case (r.st)
         ats_mode_pkg::ST_AUTO: begin
            // manual keys are ignored here; only auto key or handle leaves
            if (press[0]) begin
               nxt.st = ats_mode_pkg::ST_MANUAL;
            end
         end
         ats_mode_pkg::ST_MANUAL: begin
            if (press[0] && lim_ok) begin
               nxt.st = ats_mode_pkg::ST_AUTO;
            end else if (press[0] && lim == ats_mode_pkg::LIM_SETUP && !DISPLAY_VAR) begin
               nxt.st = ats_mode_pkg::ST_SETUP;
            end else if (press[0] && lim == ats_mode_pkg::LIM_TEST) begin
               nxt.st   = ats_mode_pkg::ST_TEST;
               nxt.step = '0;
            end else if (press[1] && !sw1_on) begin
               if (sw2_on) begin
                  nxt.sw2_open = 1'b1; // break before make
                  nxt.st       = ats_mode_pkg::ST_OPEN2;
               end else begin
                  nxt.sw1_close = 1'b1;
               end
            end else if (press[2]) begin
               nxt.sw1_open = 1'b1; // upper left as it is, off
            end else if (press[3] && !sw2_on) begin
               nxt.sw1_open  = sw1_on;
               nxt.sw2_close = !sw1_on;
               nxt.st        = sw1_on ? ats_mode_pkg::ST_CLOSE1 : r.st;
            end
         end
         ats_mode_pkg::ST_OPEN2: begin
            // wait for upper contacts to report open, then close lower
            if (!sw2_on) begin
               nxt.sw1_close = 1'b1;
               nxt.st        = ats_mode_pkg::ST_MANUAL;
            end
         end
         ats_mode_pkg::ST_CLOSE1: begin
            // lower must be off before upper closes
            if (!sw1_on) begin
               nxt.sw2_close = 1'b1;
               nxt.st        = ats_mode_pkg::ST_MANUAL;
            end
         end
         ats_mode_pkg::ST_SETUP: begin
            if (lim != ats_mode_pkg::LIM_SETUP) begin
               nxt.st = ats_mode_pkg::ST_MANUAL;
            end else if (press[0]) begin
               // step through mode first, then switch type
               if (r.opm == ats_mode_pkg::OPM_MANBK) begin
                  nxt.opm = ats_mode_pkg::OPM_LINE1;
                  nxt.swt = (r.swt == ats_mode_pkg::SWT_LARGE) ? ats_mode_pkg::SWT_AUTO
                                                              : r.swt + 2'h1;
               end else begin
                  nxt.opm = r.opm + 2'h1;
               end
            end
         end
         ats_mode_pkg::ST_TEST: begin
            if (lim != ats_mode_pkg::LIM_TEST) begin
               nxt.st = ats_mode_pkg::ST_MANUAL;
            end else if (press[0]) begin
               nxt.step = (r.step == ats_mode_pkg::TEST_STEPS) ? '0 : r.step + 3'h1;
            end
         end
         default: nxt.st = ats_mode_pkg::ST_MANUAL;
      endcase

      // handle forces manual; alarm follows handle presence
      nxt.led_alarm = handle;
      if (handle) begin
         nxt.st        = ats_mode_pkg::ST_MANUAL;
         nxt.sw1_close = 1'b0;
         nxt.sw2_close = 1'b0;
         nxt.sw1_open  = 1'b0;
         nxt.sw2_open  = 1'b0;
      end
      nxt.led_auto = (nxt.st == ats_mode_pkg::ST_AUTO);

      // delay timers run only in auto mode and restart when the cause clears
      if (r.st != ats_mode_pkg::ST_AUTO || !sw_cond) begin
         nxt.sw_cnt = '0;
      end else if (tick && r.sw_cnt != sw_delay) begin
         nxt.sw_cnt = r.sw_cnt + 9'h001;
      end
      if (r.st != ats_mode_pkg::ST_AUTO || !bk_cond) begin
         nxt.bk_cnt = '0;
      end else if (tick && r.bk_cnt != bk_delay) begin
         nxt.bk_cnt = r.bk_cnt + 9'h001;
      end
      // go is a level once the full delay has elapsed
      nxt.sw_go = (r.st == ats_mode_pkg::ST_AUTO) && sw_cond && (r.sw_cnt >= sw_delay);
      nxt.bk_go = (r.st == ats_mode_pkg::ST_AUTO) && bk_cond && (r.bk_cnt >= bk_delay);
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         r         <= '0;
         r.st      <= ats_mode_pkg::ST_MANUAL;
         r.opm     <= ats_mode_pkg::OPM_LINE1;
         r.swt     <= ats_mode_pkg::SWT_AUTO;
         r.lim_pct <= ats_mode_pkg::PCT_5;
      end else begin
         r <= nxt;
      end
   end

   // outputs straight from the state register, except o_opmode and o_swtype, which pass the display selection mux, and o_led_power, tied high
   assign o_sw1_close     = r.sw1_close;
   assign o_sw1_open      = r.sw1_open;
   assign o_sw2_close     = r.sw2_close;
   assign o_sw2_open      = r.sw2_open;
   assign o_led_power     = r.s2[0] | 1'b1;
   assign o_led_auto      = r.led_auto;
   assign o_led_alarm     = r.led_alarm;
   assign o_led_line      = r.led_line;
   assign o_auto_mode     = r.led_auto;
   assign o_setup_mode    = r.st[2];
   assign o_test_mode     = r.st[3];
   assign o_test_step     = r.step;
   assign o_opmode        = eff_opm;
   assign o_swtype        = eff_swt;
   assign o_volt_lim_pct  = r.lim_pct;
   assign o_unbal_lim_pct = r.lim_pct;
   assign o_switch_go     = r.sw_go;
   assign o_back_go       = r.bk_go;
endmodule

/* sim/transfer_switch_mode_properties.sv */
// concurrent checks on the ports of the front-panel mode and key logic
`timescale 1ns/10ps
module transfer_switch_mode_properties #(
   parameter bit EXTENDED = 1'b1
) (
   input wire logic       i_ref_clk,
   input wire logic       i_rstn,
   input wire logic       i_handle,
   input wire logic       i_switch_cond,
   input wire logic       i_sw1_on,
   input wire logic       i_sw2_on,
   input wire logic       o_sw1_close,
   input wire logic       o_sw2_close,
   input wire logic       o_led_power,
   input wire logic       o_led_auto,
   input wire logic       o_led_alarm,
   input wire logic       o_auto_mode,
   input wire logic       o_setup_mode,
   input wire logic       o_test_mode,
   input wire logic [4:0] o_volt_lim_pct,
   input wire logic [4:0] o_unbal_lim_pct,
   input wire logic       o_switch_go
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // the handle sense passes two sync flops and a register, so five cycles is safe
   property p_handle_on; i_handle [*5] |-> o_led_alarm && !o_auto_mode; endproperty
   a_handle_on: assert property (p_handle_on) else $error("handle not forcing manual");
   property p_handle_off; !i_handle [*5] |-> !o_led_alarm; endproperty
   a_handle_off: assert property (p_handle_off) else $error("alarm led stuck on");
   property p_power; o_led_power; endproperty
   a_power: assert property (p_power) else $error("power led off");
   property p_led_auto; o_led_auto == o_auto_mode; endproperty
   a_led_auto: assert property (p_led_auto) else $error("auto led differs from mode");
   // closing onto a live other side would short the two lines
   property p_break1; o_sw1_close |-> !i_sw2_on; endproperty
   a_break1: assert property (p_break1) else $error("lower closed with upper on");
   property p_break2; o_sw2_close |-> !i_sw1_on; endproperty
   a_break2: assert property (p_break2) else $error("upper closed with lower on");
   property p_unbal; o_unbal_lim_pct == o_volt_lim_pct; endproperty
   a_unbal: assert property (p_unbal) else $error("unbalance limit differs");
   property p_lim_set;
      o_volt_lim_pct inside {5'h05, 5'h0A, 5'h0F, 5'h14, 5'h19, 5'h1E};
   endproperty
   a_lim_set: assert property (p_lim_set) else $error("illegal threshold");
   property p_lim_basic; EXTENDED || (o_volt_lim_pct <= 5'h14); endproperty
   a_lim_basic: assert property (p_lim_basic) else $error("basic threshold above 20");
   property p_excl; !(o_auto_mode && (o_setup_mode || o_test_mode)); endproperty
   a_excl: assert property (p_excl) else $error("auto mode with test or setup");
   property p_setup; $rose(o_setup_mode) |-> !$past(o_auto_mode); endproperty
   a_setup: assert property (p_setup) else $error("setup entered from auto");
   property p_restart; !i_switch_cond [*4] |-> !o_switch_go; endproperty
   a_restart: assert property (p_restart) else $error("switch go without condition");
   c_auto: cover property ($rose(o_auto_mode));
   c_setup: cover property ($rose(o_setup_mode));
   c_close: cover property (o_sw1_close);
endmodule
bind transfer_switch_mode_control transfer_switch_mode_properties #(.EXTENDED(EXTENDED)) i_props (
   .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_handle(i_handle), .i_switch_cond(i_switch_cond),
   .i_sw1_on(i_sw1_on), .i_sw2_on(i_sw2_on), .o_sw1_close(o_sw1_close),
   .o_sw2_close(o_sw2_close), .o_led_power(o_led_power), .o_led_auto(o_led_auto),
   .o_led_alarm(o_led_alarm), .o_auto_mode(o_auto_mode), .o_setup_mode(o_setup_mode),
   .o_test_mode(o_test_mode), .o_volt_lim_pct(o_volt_lim_pct),
   .o_unbal_lim_pct(o_unbal_lim_pct), .o_switch_go(o_switch_go));

/* sim/switch_model.sv */
// behavioural motorized change-over switch: contacts follow command pulses after travel time
`timescale 1ns/10ps
module switch_model #(
   parameter int unsigned TRAVEL = 3
) (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_sw1_close,
   input  wire logic i_sw1_open,
   input  wire logic i_sw2_close,
   input  wire logic i_sw2_open,
   output logic      o_sw1_on,
   output logic      o_sw2_on
);
   logic [TRAVEL-1:0] c1_r, o1_r, c2_r, o2_r;
   // travel delay keeps feedback late, so the design must really wait for it
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         {c1_r, o1_r, c2_r, o2_r} <= '0;
         o_sw1_on <= 1'b0;
         o_sw2_on <= 1'b0;
      end else begin
         c1_r <= {c1_r[TRAVEL-2:0], i_sw1_close};
         o1_r <= {o1_r[TRAVEL-2:0], i_sw1_open};
         c2_r <= {c2_r[TRAVEL-2:0], i_sw2_close};
         o2_r <= {o2_r[TRAVEL-2:0], i_sw2_open};
         if (c1_r[TRAVEL-1]) o_sw1_on <= 1'b1;
         if (o1_r[TRAVEL-1]) o_sw1_on <= 1'b0;
         if (c2_r[TRAVEL-1]) o_sw2_on <= 1'b1;
         if (o2_r[TRAVEL-1]) o_sw2_on <= 1'b0;
      end
   end
endmodule

/* sim/tb_transfer_switch_mode_control.sv */
// self-checking bench for the front-panel mode and key logic
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_transfer_switch_mode_control;
   localparam int unsigned SEC = 10; // shortened second keeps the 300 s return in reach
   localparam logic [8:0] DLY [4] = '{ats_mode_pkg::DELAY_S0, ats_mode_pkg::DELAY_S1,
                                     ats_mode_pkg::DELAY_S2, ats_mode_pkg::DELAY_S3};
   localparam logic [4:0] PCT [6] = '{5'h05, 5'h0A, 5'h0F, 5'h14, 5'h19, 5'h1E};
   logic       i_ref_clk = 1'b0;
   logic       i_rstn = 1'b0;
   logic [3:0] keys = 4'h0;
   logic [1:0] i_delay_sel = 2'h0;
   logic       i_delay_side = 1'b0;
   logic [2:0] i_lim_sel = 3'h0;
   logic       i_handle = 1'b0;
   logic       i_switch_cond = 1'b0;
   logic       i_back_cond = 1'b0;
   logic [4:0] disp = 5'h00;
   logic       sw1_on, sw2_on, sw1c, sw1o, sw2c, sw2o, auto_m, led_auto, alarm;
   logic       setup_m, test_m, sw_go, bk_go, led_pwr;
   logic [1:0] led_line;
   logic [2:0] step;
   logic [1:0] opm, swt;
   logic [4:0] vlim, ulim;
   logic [3:0] cmd, exp_cmd;
   logic [3:0] exp_q [$];
   int         failures = 0;
   int         comparisons = 0;
   int         sel;
   assign cmd = {sw1c, sw1o, sw2c, sw2o};
   transfer_switch_mode_control #(.SEC_CYC(SEC), .DEBOUNCE(4)) i_dut (
      .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_key_auto(keys[0]), .i_key_one(keys[1]),
      .i_key_off(keys[2]), .i_key_two(keys[3]), .i_delay_sel(i_delay_sel),
      .i_delay_side(i_delay_side), .i_lim_sel(i_lim_sel), .i_sw1_on(sw1_on),
      .i_sw2_on(sw2_on), .i_handle(i_handle), .i_switch_cond(i_switch_cond),
      .i_back_cond(i_back_cond), .i_disp_opmode(disp[1:0]), .i_disp_swtype(disp[3:2]),
      .i_disp_manbk(disp[4]), .o_sw1_close(sw1c), .o_sw1_open(sw1o), .o_sw2_close(sw2c),
      .o_sw2_open(sw2o), .o_led_power(led_pwr), .o_led_auto(led_auto), .o_led_alarm(alarm),
      .o_led_line(led_line), .o_auto_mode(auto_m), .o_setup_mode(setup_m), .o_test_mode(test_m),
      .o_test_step(step), .o_opmode(opm), .o_swtype(swt), .o_volt_lim_pct(vlim),
      .o_unbal_lim_pct(ulim), .o_switch_go(sw_go), .o_back_go(bk_go));
   switch_model i_sw (
      .i_clk(i_ref_clk), .i_rstn(i_rstn), .i_sw1_close(sw1c), .i_sw1_open(sw1o),
      .i_sw2_close(sw2c), .i_sw2_open(sw2o), .o_sw1_on(sw1_on), .o_sw2_on(sw2_on));
   initial begin
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   // every command pulse is matched in order; sampled mid-cycle where the pulse is settled
   always @(negedge i_ref_clk) begin
      if (i_rstn && cmd != 4'h0) begin
         exp_cmd = (exp_q.size() == 0) ? 4'h0 : exp_q.pop_front();
         `CHK(cmd, exp_cmd)
      end
   end
   task automatic stop_test;
      if (failures == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask
   // hold the key past the debounce window, then let all notes drain
   task automatic press(input int b);
      keys[b] = 1'b1;
      idle(10);
      keys[b] = 1'b0;
      for (int n = 0; n < 60 && exp_q.size() != 0; n++) idle(1);
      if (exp_q.size() != 0) begin
         failures++;
         stop_test();
      end
      idle(12);
   endtask
   // the go flag may rise only once the selected number of ticks has passed
   task automatic timer(input logic back, input int s);
      int n;
      n = 0;
      if (back) i_back_cond = 1'b1;
      else i_switch_cond = 1'b1;
      while (n < s * SEC + 20 && (back ? bk_go : sw_go) !== 1'b1) begin
         idle(1);
         n++;
      end
      `CHK(n >= (s > 0 ? (s - 1) * SEC : 0) && n <= s * SEC + 8, 1'b1)
      i_back_cond = 1'b0;
      i_switch_cond = 1'b0;
      idle(6);
      `CHK(back ? bk_go : sw_go, 1'b0)
   endtask
   initial begin
      void'($urandom(32'h7b6c));
      disp = 5'($urandom);
      idle(5);
      i_rstn = 1'b1;
      idle(2);
      `CHK(vlim, ats_mode_pkg::PCT_5)
      exp_q.push_back(4'h8); press(1);
      `CHK({led_pwr, led_line}, 3'h5)
      press(1);
      exp_q.push_back(4'h4); exp_q.push_back(4'h2); press(3);
      exp_q.push_back(4'h1); exp_q.push_back(4'h8); press(1);
      exp_q.push_back(4'h4); exp_q.push_back(4'h0); exp_q.pop_back(); press(2);
      for (int i = 0; i < 6; i++) begin
         i_lim_sel = 3'(i);
         idle(5);
         `CHK(vlim, PCT[i])
      end
      i_lim_sel = ats_mode_pkg::LIM_TEST;
      idle(5);
      press(0);
      `CHK({auto_m, test_m, step}, 5'h08)
      press(0);
      `CHK(step, 3'h1)
      i_lim_sel = ats_mode_pkg::LIM_SETUP;
      idle(5);
      press(0);
      `CHK({auto_m, setup_m}, 2'h1)
      for (int i = 0; i < 4; i++) begin
         press(0);
         `CHK(opm, (i == 2) ? ats_mode_pkg::OPM_LINE1 : 2'(i + 1 - (i / 3) * 3))
         `CHK(swt, (i < 2) ? ats_mode_pkg::SWT_AUTO : ats_mode_pkg::SWT_SMALL)
      end
      i_lim_sel = 3'($urandom % 6);
      idle(5);
      `CHK(setup_m, 1'b0)
      press(0);
      `CHK({auto_m, led_auto}, 2'h3)
      press(1);
      sel = $urandom % 4;
      i_delay_sel = 2'(sel);
      timer(1'b0, int'(DLY[sel]));
      timer(1'b1, int'(DLY[sel]));
      i_delay_side = 1'b1;
      timer(1'b1, ats_mode_pkg::BACK_FIXED_S);
      press(0);
      `CHK({auto_m, led_auto}, 2'h0)
      press(0);
      i_handle = 1'b1;
      idle(6);
      `CHK({auto_m, led_auto, alarm}, 3'h1)
      press(1);
      i_handle = 1'b0;
      idle(6);
      `CHK({auto_m, alarm}, 2'h0)
      disp = 5'($urandom);
      idle(2);
      `CHK({led_pwr, led_line}, {1'b1, sw2_on, sw1_on})
      stop_test();
   end
endmodule
